// *** adc_control_result_regs.sv ***
// Converter control and result registers behind an APB slave.
// Assumes the analog front end answers comparator per bit trial.
// Function
// (RULE1) Clock select bits 6-4: 100 system clock over four, 111 RC oscillator
// (RULE2) On completion the 8-bit outcome is written to the result register
// (RULE3) Software waits a full acquisition time after channel change before starting
// (RULE4) Hold capacitor is never discharged after a conversion
// (RULE5) Result undefined after power-on reset, kept over other resets
// (RULE6) Conversion resolves 256 steps, eight successive bit trials
// (RULE7) Reference select: 0x supply, 10 external pin, 11 internal fixed
// (RULE8) Setting go starts conversion; hardware clears it on completion
// (RULE9) Channel select 0-13 inputs, 1110 reserved, 1111 fixed reference
// (RULE10) Enable bit clear disables converter and its current
`default_nettype none
module adc_control_result_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rc_clock,
    input wire logic comparator,
    output logic converter_on,
    output logic [3:0] channel_select,
    output logic fixed_reference_channel,
    output logic [1:0] reference_select,
    output logic sample,
    output logic hold_discharge,
    output logic [7:0] dac_code,
    output logic conversion_done_flag
);
    typedef enum {idle, convert, finish} phase_t;
    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        phase_t phase;
        logic [3:0] bit_count;
        logic [7:0] trial;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic done;
        logic [2:0] cmp_sync;
        logic [2:0] settle;
        logic pending;
    } core_state_t;
    core_state_t st_reg;
    core_state_t st_next;
    logic [7:0] result_reg;
    logic [7:0] result_next;
    logic result_load;
    logic access;
    logic wr;

    adc_tad_if tad ();

    adc_tad_gen u_tad (
        .pclk(pclk),
        .presetn(presetn),
        .rc_clock(rc_clock),
        .tad(tad)
    );

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a[11:2] == o[11:2]);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        result_next = result_reg;
        result_load = 1'b0;
        st_next.ready = 1'b0;
        st_next.err = 1'b0;
        st_next.done = 1'b0;
        st_next.cmp_sync = {st_reg.cmp_sync[1:0], comparator};
        access = psel & penable & ~st_reg.ready;
        wr = psel & penable & st_reg.ready & pwrite & pstrb[0];
        if (access) begin
            st_next.ready = 1'b1;
            st_next.rdata = 32'h0;
            if (hit(paddr, adc_ctrl_pkg::ctrl0_offset)) begin
                st_next.rdata = {24'h0, st_reg.ctrl0};
            end else if (hit(paddr, adc_ctrl_pkg::ctrl1_offset)) begin
                st_next.rdata = {24'h0, st_reg.ctrl1};
            end else if (hit(paddr, adc_ctrl_pkg::result_offset)) begin
                st_next.rdata = {24'h0, result_reg};
            end else if (hit(paddr, adc_ctrl_pkg::analog_offset)) begin
                st_next.rdata = {24'h0, st_reg.trial};
            end else begin
                st_next.err = 1'b1;
            end
        end
        // Writes land on the edge that sees pready high
        if (wr) begin
            if (hit(paddr, adc_ctrl_pkg::ctrl0_offset)) begin
                st_next.ctrl0 = pwdata[7:0] & adc_ctrl_pkg::ctrl0_mask;
                if (st_reg.phase != idle) begin
                    st_next.ctrl0[adc_ctrl_pkg::go_bit] = pwdata[adc_ctrl_pkg::go_bit];
                end else if (!pwdata[adc_ctrl_pkg::on_bit]) begin
                    st_next.ctrl0[adc_ctrl_pkg::go_bit] = 1'b0; // (RULE10)
                end
            end else if (hit(paddr, adc_ctrl_pkg::ctrl1_offset)) begin
                st_next.ctrl1 = pwdata[7:0] & adc_ctrl_pkg::ctrl1_mask; // (RULE1) (RULE7)
            end else if (hit(paddr, adc_ctrl_pkg::result_offset)) begin
                result_next = pwdata[7:0];
                result_load = 1'b1;
            end
        end
        unique case (st_reg.phase)
            idle: begin
                if (st_reg.ctrl0[adc_ctrl_pkg::go_bit] & st_reg.ctrl0[adc_ctrl_pkg::on_bit]) begin
                    st_next.phase = convert; // (RULE8)
                    st_next.bit_count = 4'd0;
                    st_next.trial = 8'h80;
                    st_next.settle = 3'd0;
                    st_next.pending = 1'b0;
                end else if (!st_reg.ctrl0[adc_ctrl_pkg::on_bit]) begin
                    st_next.ctrl0[adc_ctrl_pkg::go_bit] = 1'b0; // (RULE10)
                end
            end
            convert: begin
                if (st_reg.settle != 3'(adc_ctrl_pkg::settle_cycles)) begin
                    st_next.settle = st_reg.settle + 3'd1;
                end
                if (tad.tick) begin
                    st_next.pending = 1'b1;
                end
                if (!st_reg.ctrl0[adc_ctrl_pkg::on_bit] ||
                    !st_next.ctrl0[adc_ctrl_pkg::go_bit]) begin
                    st_next.phase = idle; // (RULE10)
                    st_next.ctrl0[adc_ctrl_pkg::go_bit] = 1'b0;
                end else if ((tad.tick || st_reg.pending) &&
                             st_reg.settle == 3'(adc_ctrl_pkg::settle_cycles)) begin
                    // Wait until the synced comparator reflects this trial
                    st_next.pending = 1'b0;
                    st_next.settle = 3'd0;
                    // Successive approximation over 256 steps
                    st_next.trial = st_reg.trial; // (RULE6)
                    if (!st_reg.cmp_sync[2] && !st_reg.cmp_sync[1]) begin
                        st_next.trial[7 - st_reg.bit_count[2:0]] = 1'b0;
                    end
                    if (st_reg.bit_count[2:0] != 3'd7) begin
                        st_next.trial[6 - st_reg.bit_count[2:0]] = 1'b1;
                    end
                    st_next.bit_count = st_reg.bit_count + 4'd1;
                    if (st_reg.bit_count == 4'(adc_ctrl_pkg::bits_per_conv - 1)) begin
                        st_next.phase = finish;
                    end
                end
            end
            finish: begin
                result_next = st_reg.trial; // (RULE2)
                result_load = 1'b1;
                st_next.ctrl0[adc_ctrl_pkg::go_bit] = 1'b0; // (RULE8)
                st_next.done = 1'b1;
                st_next.phase = idle;
            end
        endcase
        tad.clock_select = st_reg.ctrl1[adc_ctrl_pkg::clksel_lsb +: 3];
        tad.run = (st_reg.phase == convert);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.ctrl0 <= adc_ctrl_pkg::ctrl0_reset;
            st_reg.ctrl1 <= adc_ctrl_pkg::ctrl1_reset;
            st_reg.phase <= idle;
        end else begin
            st_reg <= st_next;
        end
    end

    // Result sits outside the system reset; only power-on clears it
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            result_reg <= 8'h00; // (RULE5)
        end else if (result_load) begin
            result_reg <= result_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_on <= 1'b0;
            channel_select <= 4'h0;
            fixed_reference_channel <= 1'b0;
            reference_select <= 2'h0;
            sample <= 1'b0;
            hold_discharge <= 1'b0;
            dac_code <= 8'h00;
            conversion_done_flag <= 1'b0;
        end else begin
            converter_on <= st_reg.ctrl0[adc_ctrl_pkg::on_bit]; // (RULE10)
            channel_select <= st_reg.ctrl0[adc_ctrl_pkg::chan_lsb +: 4]; // (RULE9)
            fixed_reference_channel <=
                (st_reg.ctrl0[adc_ctrl_pkg::chan_lsb +: 4] == adc_ctrl_pkg::chan_fixed); // (RULE9)
            reference_select <= st_reg.ctrl1[adc_ctrl_pkg::ref_lsb +: 2]; // (RULE7)
            // Acquisition runs whenever enabled and idle
            sample <= st_reg.ctrl0[adc_ctrl_pkg::on_bit] && (st_reg.phase == idle); // (RULE3)
            hold_discharge <= 1'b0; // (RULE4)
            dac_code <= st_reg.trial;
            conversion_done_flag <= st_reg.done;
        end
    end

    assign prdata = st_reg.rdata;
    assign pready = st_reg.ready;
    assign pslverr = st_reg.err;
endmodule : adc_control_result_regs
`default_nettype wire

// *** adc_ctrl_pkg.sv ***
// Constants shared by the converter control block and its clock generator.
// Assumes a 100 MHz APB clock.
`default_nettype none
package adc_ctrl_pkg;
    localparam logic [11:0] ctrl0_offset = 12'h000;
    localparam logic [11:0] ctrl1_offset = 12'h004;
    localparam logic [11:0] result_offset = 12'h008;
    localparam logic [11:0] analog_offset = 12'h00c;
    localparam int on_bit = 0;
    localparam int go_bit = 1;
    localparam int chan_lsb = 2;
    localparam int clksel_lsb = 4;
    localparam int ref_lsb = 0;
    localparam logic [7:0] ctrl0_reset = 8'h00;
    localparam logic [7:0] ctrl1_reset = 8'h00;
    localparam logic [7:0] ctrl0_mask = 8'h3f;
    localparam logic [7:0] ctrl1_mask = 8'h73;
    localparam logic [2:0] clk_fosc4 = 3'h4;
    localparam logic [2:0] clk_fosc16 = 3'h5;
    localparam logic [2:0] clk_fosc64 = 3'h6;
    localparam logic [2:0] clk_rc = 3'h7;
    localparam logic [1:0] ref_ext = 2'h2;
    localparam logic [1:0] ref_fixed = 2'h3;
    localparam logic [3:0] chan_reserved = 4'he;
    localparam logic [3:0] chan_fixed = 4'hf;
    localparam int conv_steps = 256;
    localparam int bits_per_conv = 8;
    localparam int conv_extra_tad = 3;
    localparam int settle_cycles = 4;
    localparam int clk_mhz = 100;
    localparam int fosc2_cycles = 2;
endpackage : adc_ctrl_pkg
`default_nettype wire

// *** adc_tad_if.sv ***
// Conversion clock tick carrier between sequencer and clock generator.
// Assumes one pclk domain.
`default_nettype none
interface adc_tad_if;
    logic [2:0] clock_select;
    logic run;
    logic tick;
    modport gen (input clock_select, input run, output tick);
    modport use_side (output clock_select, output run, input tick);
endinterface : adc_tad_if
`default_nettype wire

// *** adc_tad_gen.sv ***
// Conversion clock tick generator.
// Assumes rc_clock is a raw pin clock, synchronised here.
`default_nettype none
module adc_tad_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rc_clock,
    adc_tad_if.gen tad
);
    typedef struct packed {
        logic [6:0] div;
        logic [2:0] rc_sync;
        logic rc_level;
        logic tick;
    } gen_state_t;
    gen_state_t st_reg;
    gen_state_t st_next;
    logic [6:0] limit;

    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        st_next.rc_sync = {st_reg.rc_sync[1:0], rc_clock};
        unique case (tad.clock_select)
            adc_ctrl_pkg::clk_fosc16: limit = 7'd7;
            adc_ctrl_pkg::clk_fosc64: limit = 7'd31;
            default: limit = 7'd1;
        endcase
        if (!tad.run) begin
            st_next.div = 7'd0;
        end else if (tad.clock_select == adc_ctrl_pkg::clk_rc) begin
            if (st_reg.rc_sync[2] == st_reg.rc_sync[1]) begin
                st_next.rc_level = st_reg.rc_sync[1];
                st_next.tick = st_reg.rc_sync[1] & ~st_reg.rc_level; // (RULE1)
            end
        end else if (st_reg.div >= limit) begin
            st_next.div = 7'd0;
            st_next.tick = 1'b1; // (RULE1)
        end else begin
            st_next.div = st_reg.div + 7'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tad.tick = st_reg.tick;
endmodule : adc_tad_gen
`default_nettype wire

// *** adc_ctrl_monitor.sv ***
// Port checker for the converter control block.
// Assumes a bind into the block, one pclk domain.
`default_nettype none
module adc_ctrl_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic converter_on,
    input wire logic [3:0] channel_select,
    input wire logic fixed_reference_channel,
    input wire logic sample,
    input wire logic hold_discharge,
    input wire logic conversion_done_flag
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    a_hold_kept: assert property (hold_discharge == 1'b0)
        else $error("hold discharged");
    a_fixed_chan: assert property (fixed_reference_channel == (channel_select == 4'hf))
        else $error("fixed channel mismatch");
    a_off_idle: assert property (!converter_on |-> !sample)
        else $error("sampling while off");
    a_done_pulse: assert property (conversion_done_flag |=> !conversion_done_flag)
        else $error("done not a pulse");
    a_done_after_conv: assert property (conversion_done_flag |-> $past(!sample, 4))
        else $error("done without conversion");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_one_wait: assert property ($rose(penable) && psel |=> pready)
        else $error("answer not after one wait");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held");
    c_done: cover property (conversion_done_flag);
    c_err: cover property (pslverr);
    c_fixed: cover property (fixed_reference_channel);
endmodule : adc_ctrl_monitor
`default_nettype wire

// *** adc_front_model.sv ***
// Analog front end model: comparator against the trial code.
// Assumes the level input holds the applied voltage in steps.
`default_nettype none
module adc_front_model (
    input wire logic [7:0] dac_code,
    input wire logic [7:0] level,
    output logic comparator
);
    // Level sits mid-step; held charge stays between conversions
    assign comparator = ({level, 1'b1} > {dac_code, 1'b0});
endmodule : adc_front_model
`default_nettype wire

// *** test_adc_control_result_regs.sv ***
// Self-checking bench for the converter control block.
// Assumes the front end model and the port checker.
`default_nettype none
module test_adc_control_result_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic rc_clock = 1'b0;
    logic presetn, por_n, psel, penable, pwrite, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, d, seed;
    logic [3:0] pstrb, channel_select;
    logic pready, pslverr, comparator, converter_on, fixed_reference_channel;
    logic sample, hold_discharge, conversion_done_flag;
    logic [1:0] reference_select;
    logic [7:0] dac_code, level;
    int fail_count = 0;
    int total_checks = 0;
    int done_seen = 0;
    always #5 pclk = ~pclk;
    always #35 rc_clock = ~rc_clock;
    always @(posedge pclk) if (conversion_done_flag === 1'b1) done_seen++;
    ////////////////////////////////////////////////////////////////////////
    adc_control_result_regs i_adc_control_result_regs (.pclk, .presetn, .por_n,
        .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .rc_clock, .comparator, .converter_on, .channel_select,
        .fixed_reference_channel, .reference_select, .sample, .hold_discharge,
        .dac_code, .conversion_done_flag);
    adc_front_model i_adc_front_model (.dac_code, .level, .comparator);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report
    initial begin
        #300us;
        fail_count++;
        final_report();
    end
    initial begin
        {psel, penable, pwrite, presetn, por_n} = 5'h00;
        {paddr, pwdata, level, seed} = {12'h000, 32'h0, 8'h00, 32'd90};
        pstrb = 4'hf;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        apb(0, 12'h000, 0); chk(r, 32'h0);
        apb(0, 12'h004, 0); chk(r, 32'h0);
        apb(0, 12'h010, 0); chk(last_err, 1'b1);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            d = {seed[31:7], i[2:0], seed[3:2], i[1:0]};
            apb(1, 12'h004, d);
            apb(0, 12'h004, 0); chk(r, {24'h0, d[7:0] & 8'h73});
            chk(reference_select, i[1:0]);
        end
        for (int j = 0; j < 16; j++) begin
            seed = xs(seed);
            apb(1, 12'h000, {seed[31:6], j[3:0], 2'h1});
            apb(0, 12'h000, 0); chk(r, {26'h0, j[3:0], 2'h1});
            chk(channel_select, j[3:0]);
            chk(fixed_reference_channel, j == 15);
            chk(converter_on, 1'b1);
        end
        pstrb <= 4'he;
        apb(1, 12'h000, 32'h0);
        pstrb <= 4'hf;
        apb(0, 12'h000, 0); chk(r, 32'h3d);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            level <= (k == 0) ? 8'hff : (k == 1) ? 8'h00 : seed[7:0];
            apb(1, 12'h004, {25'h0, 3'h4 + k[2:0], 4'h0});
            apb(1, 12'h000, {26'h0, k[3:0], 2'h1});
            repeat (50) @(posedge pclk);
            apb(1, 12'h000, {26'h0, k[3:0], 2'h3});
            for (int n = 0; n == 0 || (n < 300 && r[1] !== 1'b0); n++)
                apb(0, 12'h000, 0);
            chk(r[1], 1'b0);
            apb(0, 12'h008, 0); chk(r, {24'h0, level});
            chk(dac_code, {24'h0, level});
            chk(done_seen, k + 1);
            chk(hold_discharge, 1'b0);
            chk(sample, 1'b1);
        end
        apb(1, 12'h000, 32'h0f);
        apb(1, 12'h000, 32'h0c);
        apb(0, 12'h000, 0); chk(r, 32'h0c);
        chk(done_seen, 4);
        chk(sample, 1'b0);
        apb(1, 12'h008, 32'ha5);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h008, 0); chk(r, 32'ha5);
        apb(0, 12'h000, 0); chk(r, 32'h0);
        chk(converter_on, 1'b0);
        por_n <= 1'b0;
        @(posedge pclk);
        por_n <= 1'b1;
        apb(0, 12'h008, 0); chk(r, 32'h0);
        final_report();
    end
endmodule : test_adc_control_result_regs
bind adc_control_result_regs adc_ctrl_monitor i_adc_ctrl_monitor (.pclk, .presetn,
    .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .converter_on,
    .channel_select, .fixed_reference_channel, .sample, .hold_discharge,
    .conversion_done_flag);
`default_nettype wire
